// ### tsp_dev.sv
// Device end of the touch controller serial port: shifter on the link clock.
//
// Overview of operation
// - Slave only, idle-low clock, output changes falling.
// - Host makes every clock edge.
// - Host ties mode strap high for serial.
// - Interrupt rises when a packet becomes pending.
// - Interrupt drops after first packet byte out.
// - Deselected: data output released, not driven.
// - Each clock shifts one bit in, one out.
// - Bytes travel most significant bit first.
// - Nothing queued: device sends filler byte.
// - Host keeps clock at or under top rate.
// - Host waits inter-byte gap between bytes.
// - Command in, interrupt, then response out.
// - Reports are interrupt driven, host reads all.
// - Host waits after select before first rise.
// - Host holds select after last falling edge.
// - Report is five bytes: pen, X, Y.
// - Pen bit one touched, zero lifted.
module tsp_dev (
  input  wire logic              ref_clk,
  input  wire logic              rst_b,
  tsp_if.dev                     link,
  input  wire logic              rpt_valid,
  input  wire tsp_pkg::tsp_coord_t rpt_x,
  input  wire tsp_pkg::tsp_coord_t rpt_y,
  input  wire logic              rpt_pen,
  input  wire logic              rsp_valid,
  input  wire tsp_pkg::tsp_idx_t rsp_len,
  input  wire tsp_pkg::tsp_pkt_t rsp_data,
  output logic                   pkt_ready,
  output logic                   cmd_valid,
  output tsp_pkg::tsp_byte_t     cmd_byte,
  output logic                   busy
);
  import tsp_pkg::*;

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic      strap_s1;
  logic      strap_s2;
  logic      link_rst_b;
  tsp_idx_t  bit_cnt;
  tsp_byte_t rx_shift;
  tsp_byte_t rx_hold;
  logic      rx_tgl;
  logic      sdo_q;
  logic      first_bit;
  logic      tgl_s1;
  logic      tgl_s2;
  logic      tgl_s3;
  logic      byte_evt;
  tsp_pkt_t  pkt_vec;
  tsp_pkt_t  rpt_vec;
  tsp_idx_t  pkt_len;
  tsp_idx_t  idx;
  logic      pending;
  logic      irq;
  tsp_byte_t tx_byte;
  logic      load_rsp;
  logic      load_rpt;

  // ----------------------------------------------------------------------
  // Mode strap
  // ----------------------------------------------------------------------

  // The strap is a board pin, so it passes two flops before use.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      strap_s1 <= 1'b0;
      strap_s2 <= 1'b0;
    end else begin
      strap_s1 <= link.interface_mode_strap;
      strap_s2 <= strap_s1;
    end
  end

  // ----------------------------------------------------------------------
  // Link clock domain
  // ----------------------------------------------------------------------

  // The shifter is held in reset whenever select is high, so a selected
  // transfer always begins on a byte boundary. With select tied low the
  // reset only comes from the chip reset and bytes are framed by count.
  // deselect clears framing
  assign link_rst_b = rst_b & ~link.ss_b;

  // Bit counter advances on each rising edge and wraps after eight.
  // eight-clock framing
  always_ff @(posedge link.sck or negedge link_rst_b) begin
    if (!link_rst_b) begin
      bit_cnt <= IDX_ZERO;
    end else begin
      bit_cnt <= bit_cnt + 3'h1;
    end
  end

  // Input bits are taken on the rising edge, first bit landing on top.
  // one bit in per clock
  always_ff @(posedge link.sck or negedge link_rst_b) begin
    if (!link_rst_b) begin
      rx_shift <= 8'h00;
    end else begin
      rx_shift <= {rx_shift[BIT_MSB-1:0], link.sdi};
    end
  end

  // A finished byte is parked in a holding register and announced by a
  // toggle. Neither is cleared by select, or the toggle would fake an event.
  always_ff @(posedge link.sck or negedge rst_b) begin
    if (!rst_b) begin
      rx_hold <= 8'h00;
      rx_tgl  <= 1'b0;
    end else if (bit_cnt == BIT_LAST) begin
      rx_hold <= {rx_shift[BIT_MSB-1:0], link.sdi};
      rx_tgl  <= ~rx_tgl;
    end
  end

  // Output bits change on the falling edge. After rising edge k the next
  // bit is 7-k, which for a three-bit count is simply its inverse.
  // change on falling edge
  always_ff @(negedge link.sck or negedge link_rst_b) begin
    if (!link_rst_b) begin
      sdo_q     <= 1'b0;
      first_bit <= 1'b1;
    end else begin
      first_bit <= 1'b0;
      sdo_q     <= tx_byte[~bit_cnt];
    end
  end

  // Before the first falling edge of a selection the top bit must already
  // be on the pin, because the host samples it during the very first high phase.
  // MSB first out
  assign link.sdo = first_bit ? tx_byte[BIT_MSB] : sdo_q;

  assign link.sdo_oe = ~link.ss_b & strap_s2;

  // ----------------------------------------------------------------------
  // Crossing into the reference clock domain
  // ----------------------------------------------------------------------

  // Byte toggle passes two flops; a third copy feeds the edge detector.
  // The held byte is stable for the whole inter-byte gap, far longer
  // than the synchroniser delay, so it is read directly on the event.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tgl_s1 <= 1'b0;
      tgl_s2 <= 1'b0;
      tgl_s3 <= 1'b0;
    end else begin
      tgl_s1 <= rx_tgl;
      tgl_s2 <= tgl_s1;
      tgl_s3 <= tgl_s2;
    end
  end

  assign byte_evt = tgl_s2 ^ tgl_s3;

  // Every byte the host clocks in while the mode strap is high is passed to the command decoder.
  // command bytes delivered
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_valid <= 1'b0;
      cmd_byte  <= 8'h00;
    end else begin
      cmd_valid <= byte_evt & strap_s2;
      if (byte_evt) begin
        cmd_byte <= rx_hold;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Packet queue, one packet deep
  // ----------------------------------------------------------------------

  assign rpt_vec = {RPT_HEAD_HI, rpt_pen,
                    RPT_ZERO, rpt_x[6:0], RPT_PAD, rpt_x[11:7],
                    RPT_ZERO, rpt_y[6:0], RPT_PAD, rpt_y[11:7]};

  // A response wins over a report offered in the same cycle. A response
  // of zero length or longer than the buffer is not taken.
  assign pkt_ready = ~pending & strap_s2;
  assign load_rsp  = pkt_ready & rsp_valid & (rsp_len != IDX_ZERO) & (rsp_len <= RPT_LEN);
  assign load_rpt  = pkt_ready & rpt_valid & ~load_rsp;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pkt_vec <= '0;
      pkt_len <= IDX_ZERO;
    end else if (load_rsp) begin
      pkt_vec <= rsp_data;
      pkt_len <= rsp_len;
    end else if (load_rpt) begin
      pkt_vec <= rpt_vec;
      pkt_len <= RPT_LEN;
    end
  end

  // Each finished byte while a packet is pending moves the read index;
  // the last one frees the buffer. Loading and draining never overlap.
  // host drains whole packet
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pending <= 1'b0;
      idx     <= IDX_ZERO;
    end else if (load_rsp | load_rpt) begin
      pending <= 1'b1;
      idx     <= IDX_ZERO;
    end else if (byte_evt & pending) begin
      if (idx == pkt_len - 3'h1) begin
        pending <= 1'b0;
        idx     <= IDX_ZERO;
      end else begin
        idx <= idx + 3'h1;
      end
    end
  end

  // Interrupt rises with a new packet and falls once its first byte is out.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else if (load_rsp | load_rpt) begin
      irq <= 1'b1;
    end else if (byte_evt & pending) begin
      irq <= 1'b0;
    end
  end

  assign link.data_ready_irq = irq;
  assign busy                = pending;

  // Byte presented to the link. It only changes a few reference cycles after
  // the last rising edge of a byte, while the link clock is still high, so the
  // shifter sees a settled value at the last falling edge. A packet offered
  // while the host is mid-byte would break that; hosts wait for the
  // interrupt, which keeps them clear of it.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_byte <= FILLER_BYTE;
    end else if (pending) begin
      tx_byte <= pkt_vec[PKT_W - 1 - 8 * int'(idx) -: 8];
    end else begin
      tx_byte <= FILLER_BYTE;
    end
  end

endmodule : tsp_dev

// ### tsp_host.sv
// Host end of the touch controller serial port: link master on ref_clk.
module tsp_host #(
  parameter int GAP_CYC = tsp_pkg::INTERBYTE_CYC
) (
  input  wire logic               ref_clk,
  input  wire logic               rst_b,
  tsp_if.host                     link,
  input  wire logic               xfer_valid,
  input  wire tsp_pkg::tsp_byte_t xfer_byte,
  output logic                    xfer_ready,
  output logic                    rx_valid,
  output tsp_pkg::tsp_byte_t      rx_byte,
  output logic                    irq_seen
);
  import tsp_pkg::*;

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  tsp_host_state_t state;
  tsp_cnt_t        cnt;
  tsp_idx_t        bits;
  tsp_byte_t       tx;
  tsp_byte_t       rx;
  logic            sdo_s1;
  logic            sdo_s2;
  logic            irq_s1;
  logic            irq_s2;
  logic            cnt_done;

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------

  // Device pins are asynchronous to ref_clk.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sdo_s1 <= 1'b0;
      sdo_s2 <= 1'b0;
      irq_s1 <= 1'b0;
      irq_s2 <= 1'b0;
    end else begin
      sdo_s1 <= link.sdo;
      sdo_s2 <= sdo_s1;
      irq_s1 <= link.data_ready_irq;
      irq_s2 <= irq_s1;
    end
  end

  assign irq_seen   = irq_s2;
  // strap held high for serial mode
  assign link.interface_mode_strap = 1'b1;
  assign xfer_ready = (state == TSP_IDLE);
  assign cnt_done   = (cnt == CNT_ZERO);

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state     <= TSP_IDLE;
      cnt       <= CNT_ZERO;
      bits      <= IDX_ZERO;
      link.sck  <= 1'b0;
      link.ss_b <= 1'b1;
    end else begin
      case (state)
        TSP_IDLE: begin
          if (xfer_valid) begin
            link.ss_b <= 1'b0;
            bits      <= IDX_ZERO;
            cnt       <= CNT_W'(SS_LEAD_CYC - 1);
            state     <= TSP_LEAD;
          end
        end
        TSP_LEAD: begin
          if (cnt_done) begin
            link.sck <= 1'b1;
            // half period keeps rate in limit
            cnt      <= CNT_W'(SCK_HALF_CYC - 1);
            state    <= TSP_HIGH;
          end else begin
            cnt <= cnt - 14'h0001;
          end
        end
        TSP_HIGH: begin
          if (cnt_done) begin
            link.sck <= 1'b0;
            bits     <= bits + 3'h1;
            if (bits == BIT_LAST) begin
              cnt   <= CNT_W'(SS_TRAIL_CYC - 1);
              state <= TSP_TRAIL;
            end else begin
              cnt   <= CNT_W'(SCK_HALF_CYC - 1);
              state <= TSP_LOW;
            end
          end else begin
            cnt <= cnt - 14'h0001;
          end
        end
        TSP_LOW: begin
          if (cnt_done) begin
            link.sck <= 1'b1;
            cnt      <= CNT_W'(SCK_HALF_CYC - 1);
            state    <= TSP_HIGH;
          end else begin
            cnt <= cnt - 14'h0001;
          end
        end
        TSP_TRAIL: begin
          if (cnt_done) begin
            link.ss_b <= 1'b1;
            cnt       <= CNT_W'(GAP_CYC - 1);
            state     <= TSP_GAP;
          end else begin
            cnt <= cnt - 14'h0001;
          end
        end
        TSP_GAP: begin
          if (cnt_done) begin
            state <= TSP_IDLE;
          end else begin
            cnt <= cnt - 14'h0001;
          end
        end
        default: begin
          state     <= TSP_IDLE;
          link.sck  <= 1'b0;
          link.ss_b <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Data shifting
  // ----------------------------------------------------------------------

  // Output bits change with the falling clock; input bits are taken at the
  // end of the high phase, when the device output has long settled.
  // MSB first both ways
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx       <= 8'h00;
      rx       <= 8'h00;
      link.sdi <= 1'b0;
      rx_valid <= 1'b0;
      rx_byte  <= 8'h00;
    end else begin
      rx_valid <= 1'b0;
      if (state == TSP_IDLE && xfer_valid) begin
        tx       <= xfer_byte;
        link.sdi <= xfer_byte[BIT_MSB];
      end else if (state == TSP_HIGH && cnt_done) begin
        tx       <= {tx[BIT_MSB-1:0], 1'b0};
        link.sdi <= tx[BIT_MSB-1];
        rx       <= {rx[BIT_MSB-1:0], sdo_s2};
        if (bits == BIT_LAST) begin
          rx_valid <= 1'b1;
          rx_byte  <= {rx[BIT_MSB-1:0], sdo_s2};
        end
      end
    end
  end

endmodule : tsp_host

// ### tsp_if.sv
// Pin bundle between the touch controller port and its host.
interface tsp_if;
  logic sck;
  logic ss_b;
  logic sdi;
  logic sdo;
  logic sdo_oe;
  logic data_ready_irq;
  logic interface_mode_strap;

  modport dev (
    input  sck,
    input  ss_b,
    input  sdi,
    input  interface_mode_strap,
    output sdo,
    output sdo_oe,
    output data_ready_irq
  );

  modport host (
    output sck,
    output ss_b,
    output sdi,
    output interface_mode_strap,
    input  sdo,
    input  sdo_oe,
    input  data_ready_irq
  );
endinterface : tsp_if

// ### tsp_pkg.sv
// Shared constants and types for the touch controller serial port, both ends.
package tsp_pkg;

  // ----------------------------------------------------------------------
  // Clock and link timing
  // ----------------------------------------------------------------------
  localparam int REF_PERIOD_NS   = 4;
  localparam int SCK_MAX_KHZ     = 900;
  localparam int SCK_HALF_MIN_NS = 550;
  // Half period needed to stay at or under the top bit rate, rounded up.
  localparam int SCK_RATE_HALF_NS = (1000000 + 2 * SCK_MAX_KHZ - 1) / (2 * SCK_MAX_KHZ);
  localparam int SCK_HALF_NS = (SCK_RATE_HALF_NS > SCK_HALF_MIN_NS) ?
                               SCK_RATE_HALF_NS : SCK_HALF_MIN_NS;
  localparam int SCK_HALF_CYC  = (SCK_HALF_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
  localparam int SS_LEAD_NS    = 500;
  localparam int SS_LEAD_CYC   = (SS_LEAD_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
  localparam int SS_TRAIL_NS   = 800;
  localparam int SS_TRAIL_CYC  = (SS_TRAIL_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
  localparam int INTERBYTE_US  = 50;
  localparam int INTERBYTE_CYC = (INTERBYTE_US * 1000 + REF_PERIOD_NS - 1) / REF_PERIOD_NS;

  localparam int CNT_W = 14;
  typedef logic [CNT_W-1:0] tsp_cnt_t;
  localparam tsp_cnt_t CNT_ZERO = 14'h0000;

  // ----------------------------------------------------------------------
  // Byte and packet layout
  // ----------------------------------------------------------------------
  typedef logic [7:0]  tsp_byte_t;
  typedef logic [11:0] tsp_coord_t;
  typedef logic [2:0]  tsp_idx_t;
  localparam int       PKT_BYTES   = 5;
  localparam int       PKT_W       = PKT_BYTES * 8;
  typedef logic [PKT_W-1:0] tsp_pkt_t;
  localparam tsp_idx_t RPT_LEN     = 3'h5;
  localparam tsp_idx_t IDX_ZERO    = 3'h0;
  localparam tsp_idx_t BIT_LAST    = 3'h7;
  localparam int       BIT_MSB     = 7;
  localparam tsp_byte_t FILLER_BYTE = 8'h4D;
  localparam logic [6:0] RPT_HEAD_HI = 7'h40;
  localparam logic [2:0] RPT_PAD    = 3'h0;
  localparam logic       RPT_ZERO   = 1'h0;

  // Host sequencer states, one bit apart on each step except high to trail and gap to idle.
  typedef enum logic [2:0] {
    TSP_IDLE  = 3'b000,
    TSP_LEAD  = 3'b001,
    TSP_HIGH  = 3'b011,
    TSP_LOW   = 3'b010,
    TSP_TRAIL = 3'b110,
    TSP_GAP   = 3'b111
  } tsp_host_state_t;

endpackage : tsp_pkg

// ### tsp_props.sv
// Checker for the serial link between the touch port device and its host.
module tsp_props #(
  parameter int GAP_CYC = tsp_pkg::INTERBYTE_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic sck,
  input wire logic ss_b,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire logic data_ready_irq,
  input wire logic interface_mode_strap
);
  import tsp_pkg::*;

  // ----------------------------------------------------------------------
  // Phase counters
  // ----------------------------------------------------------------------
  logic        sck_q;
  logic [15:0] hi_cnt;
  logic [15:0] lo_cnt;
  logic [15:0] lead_cnt;
  logic [15:0] gap_cnt;
  logic [3:0]  rise_cnt;

  // The gap counter starts saturated so the first select after reset is legal.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sck_q    <= 1'b0;
      hi_cnt   <= 16'h0000;
      lo_cnt   <= 16'h0000;
      lead_cnt <= 16'h0000;
      gap_cnt  <= 16'hFFFF;
      rise_cnt <= 4'h0;
    end else begin
      sck_q    <= sck;
      hi_cnt   <= sck ? hi_cnt + 16'h0001 : 16'h0000;
      lo_cnt   <= sck ? 16'h0000 : lo_cnt + 16'h0001;
      lead_cnt <= ss_b ? 16'h0000 : lead_cnt + 16'h0001;
      gap_cnt  <= !ss_b ? 16'h0000 : ((&gap_cnt) ? gap_cnt : gap_cnt + 16'h0001);
      rise_cnt <= ss_b ? 4'h0 : ((sck && !sck_q) ? rise_cnt + 4'h1 : rise_cnt);
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  sequence sel_s;
    (!ss_b && interface_mode_strap) [*3];
  endsequence
  sequence first_byte_s;
    !ss_b && (rise_cnt == 4'h8);
  endsequence

  // ----------------------------------------------------------------------
  // Link assertions
  // ----------------------------------------------------------------------
  oe_deselect_a: assert property (ss_b |-> !sdo_oe)
    else $error("data output driven while deselected");
  oe_select_a: assert property (sel_s |-> sdo_oe)
    else $error("data output released while selected");
  shift_hold_a: assert property (!ss_b && sck && $past(sck) |-> $stable(sdo) && $stable(sdi))
    else $error("data moved during clock high phase");
  sck_idle_a: assert property (ss_b |-> !sck)
    else $error("clock not idle low while deselected");
  high_time_a: assert property ($fell(sck) |-> hi_cnt >= SCK_HALF_CYC)
    else $error("clock high phase too short");
  low_time_a: assert property ($rose(sck) && rise_cnt != 4'h0 |-> lo_cnt >= SCK_HALF_CYC)
    else $error("clock low phase too short");
  lead_time_a: assert property ($rose(sck) |-> lead_cnt >= SS_LEAD_CYC)
    else $error("first clock too soon after select");
  trail_time_a: assert property ($rose(ss_b) |-> lo_cnt >= SS_TRAIL_CYC)
    else $error("deselect too soon after last clock");
  byte_count_a: assert property ($rose(ss_b) |-> rise_cnt == 4'h8)
    else $error("frame did not carry eight clocks");
  gap_time_a: assert property ($fell(ss_b) |-> gap_cnt >= GAP_CYC)
    else $error("byte started inside the gap");
  irq_clear_a: assert property ($fell(data_ready_irq) |-> first_byte_s)
    else $error("interrupt dropped before a whole byte");
  irq_hold_a: assert property (data_ready_irq && ss_b |=> data_ready_irq)
    else $error("interrupt dropped with no transfer");
  strap_high_a: assert property (interface_mode_strap)
    else $error("mode strap not high");
endmodule : tsp_props

// ### tsp_tb_top.sv
// Testbench joining the host end and the device end of the touch serial port.
module tsp_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import tsp_pkg::*;

  localparam int GAP       = 50;
  localparam int CYC_LIMIT = 90000;

  logic       ref_clk    = 1'b0;
  logic       rst_b      = 1'b1;
  logic       xfer_valid = 1'b0;
  tsp_byte_t  xfer_byte  = 8'h00;
  logic       rpt_valid  = 1'b0;
  logic       rpt_pen    = 1'b0;
  logic       rsp_valid  = 1'b0;
  tsp_coord_t rpt_x      = 12'h000;
  tsp_coord_t rpt_y      = 12'h000;
  tsp_idx_t   rsp_len    = 3'h0;
  tsp_pkt_t   rsp_data   = 40'h0000000000;
  logic       xfer_ready, rx_valid, irq_seen, pkt_ready, cmd_valid, busy, sck_q;
  tsp_byte_t  rx_byte, cmd_byte, f_cmd_byte;
  logic [7:0] cmd_cnt = 8'h00;
  logic [7:0] n_rise = 8'h00;
  logic [7:0] mon_sdi, mon_sdo, mon_last;
  int         miscompares = 0;
  int         samples_checked = 0;
  int         cyc = 0;

  tsp_if link ();
  tsp_if flt ();

  tsp_host #(.GAP_CYC(GAP)) i_tsp_host (.ref_clk(ref_clk), .rst_b(rst_b), .link(link.host),
    .xfer_valid(xfer_valid), .xfer_byte(xfer_byte), .xfer_ready(xfer_ready),
    .rx_valid(rx_valid), .rx_byte(rx_byte), .irq_seen(irq_seen));
  tsp_dev i_tsp_dev (.ref_clk(ref_clk), .rst_b(rst_b), .link(link.dev), .rpt_valid(rpt_valid),
    .rpt_x(rpt_x), .rpt_y(rpt_y), .rpt_pen(rpt_pen), .rsp_valid(rsp_valid), .rsp_len(rsp_len),
    .rsp_data(rsp_data), .pkt_ready(pkt_ready), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
    .busy(busy));
  // Second device faces the bench, which breaks framing on purpose.
  tsp_dev i_tsp_dev_fault (.ref_clk(ref_clk), .rst_b(rst_b), .link(flt.dev),
    .rpt_valid(rpt_valid), .rpt_x(rpt_x), .rpt_y(rpt_y), .rpt_pen(rpt_pen),
    .rsp_valid(rsp_valid), .rsp_len(rsp_len), .rsp_data(rsp_data), .pkt_ready(),
    .cmd_valid(), .cmd_byte(f_cmd_byte), .busy());
  tsp_props #(.GAP_CYC(GAP)) i_tsp_props (.ref_clk(ref_clk), .rst_b(rst_b), .sck(link.sck),
    .ss_b(link.ss_b), .sdi(link.sdi), .sdo(link.sdo), .sdo_oe(link.sdo_oe),
    .data_ready_irq(link.data_ready_irq), .interface_mode_strap(link.interface_mode_strap));

  always #2 ref_clk = ~ref_clk;

  // Wire monitor: bits as seen at each clock rise, plus the hang limit.
  always @(posedge ref_clk) begin
    sck_q <= link.sck;
    cyc <= cyc + 1;
    if (cmd_valid === 1'b1) cmd_cnt <= cmd_cnt + 8'h01;
    if (link.ss_b !== 1'b0) n_rise <= 8'h00;
    else if (link.sck && !sck_q) begin
      n_rise <= n_rise + 8'h01;
      mon_sdi <= {mon_sdi[6:0], link.sdi};
      mon_sdo <= {mon_sdo[6:0], link.sdo};
    end
    if (cyc == CYC_LIMIT) begin
      miscompares++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task print_verdict;
    if (miscompares == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict

  // One host byte; the waits are bounded so a stuck end shows as a mismatch.
  task automatic xfer(input tsp_byte_t tx, output tsp_byte_t rx);
    int n;
    @(posedge ref_clk);
    xfer_valid <= 1'b1;
    xfer_byte <= tx;
    @(posedge ref_clk);
    xfer_valid <= 1'b0;
    for (n = 0; n < 4000 && rx_valid !== 1'b1; n++) @(negedge ref_clk);
    check({7'h00, rx_valid}, 8'h01);
    rx = rx_byte;
    mon_last = n_rise;
    for (n = 0; n < 4000 && xfer_ready !== 1'b1; n++) @(negedge ref_clk);
    check({7'h00, xfer_ready}, 8'h01);
  endtask : xfer

  task automatic offer(input logic rv, input logic sv, input tsp_idx_t len, input tsp_pkt_t d,
                       input tsp_coord_t x, input tsp_coord_t y, input logic pen,
                       input logic [7:0] exp_busy);
    check({7'h00, pkt_ready}, 8'h01);
    @(posedge ref_clk);
    {rpt_valid, rsp_valid, rsp_len, rsp_data} <= {rv, sv, len, d};
    {rpt_x, rpt_y, rpt_pen} <= {x, y, pen};
    @(posedge ref_clk);
    {rpt_valid, rsp_valid} <= 2'h0;
    repeat (6) @(negedge ref_clk);
    check({7'h00, busy}, exp_busy);
    check({7'h00, irq_seen}, exp_busy);
  endtask : offer

  // Bench-driven clocking of the second device, sampling its output before each rise.
  // Each half is six reference cycles, a 48 ns link clock period.
  task automatic bb(input tsp_byte_t tx, input int nbits, output tsp_byte_t rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nbits; i--) begin
      flt.sdi <= tx[i];
      repeat (6) @(posedge ref_clk);
      rx[i] = flt.sdo;
      flt.sck <= 1'b1;
      repeat (6) @(posedge ref_clk);
      flt.sck <= 1'b0;
    end
    repeat (20) @(posedge ref_clk);
  endtask : bb

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    tsp_byte_t  rx;
    tsp_pkt_t   exp;
    tsp_coord_t x, y;
    {flt.sck, flt.ss_b, flt.sdi, flt.interface_mode_strap} = 4'b0101;
    // A real falling edge on reset, so flops reset only by that edge start known.
    rst_b <= 1'b0;
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (10) @(posedge ref_clk);
    // A partial byte is dropped when select goes away.
    flt.ss_b <= 1'b0;
    repeat (130) @(posedge ref_clk);
    check({7'h00, flt.sdo_oe}, 8'h01);
    bb(8'hFF, 3, rx);
    flt.ss_b <= 1'b1;
    repeat (4) @(posedge ref_clk);
    check({7'h00, flt.sdo_oe}, 8'h00);
    repeat (60) @(posedge ref_clk);
    // With the mode strap low the selected device must not drive its output.
    flt.ss_b <= 1'b0;
    flt.interface_mode_strap <= 1'b0;
    repeat (4) @(posedge ref_clk);
    check({7'h00, flt.sdo_oe}, 8'h00);
    flt.interface_mode_strap <= 1'b1;
    repeat (130) @(posedge ref_clk);
    bb(8'hA5, 8, rx);
    check(rx, FILLER_BYTE);
    check(f_cmd_byte, 8'hA5);
    repeat (60) @(posedge ref_clk);
    bb(8'h3C, 8, rx);
    check(rx, FILLER_BYTE);
    check(f_cmd_byte, 8'h3C);
    flt.ss_b <= 1'b1;
    // Nothing pending: filler out, command byte in, both checked on the wire too.
    xfer(8'h12, rx);
    check(rx, FILLER_BYTE);
    check(mon_sdi, 8'h12);
    check(mon_sdo, FILLER_BYTE);
    check(mon_last, 8'h08);
    check(cmd_byte, 8'h12);
    check(cmd_cnt, 8'h01);
    // Touch reports with pen down, then pen lifted.
    for (int p = 1; p >= 0; p--) begin
      x = (p == 1) ? 12'hABC : 12'h5A3;
      y = (p == 1) ? 12'h123 : 12'hFED;
      exp = {1'b1, 6'h00, p[0], 1'b0, x[6:0], 3'h0, x[11:7], 1'b0, y[6:0], 3'h0, y[11:7]};
      offer(1'b1, 1'b0, 3'h0, 40'h0000000000, x, y, p[0], 8'h01);
      for (int b = 0; b < PKT_BYTES; b++) begin
        xfer(8'h00, rx);
        check(rx, exp[39 - 8 * b -: 8]);
        if (b == 0) check({7'h00, irq_seen}, 8'h00);
      end
      check({7'h00, busy}, 8'h00);
      xfer(8'h00, rx);
      check(rx, FILLER_BYTE);
    end
    // A response offered with a report wins; only its length goes out.
    offer(1'b1, 1'b1, 3'h2, 40'h5501A5A5A5, 12'h111, 12'h222, 1'b1, 8'h01);
    xfer(8'h00, rx);
    check(rx, 8'h55);
    check({7'h00, irq_seen}, 8'h00);
    xfer(8'h00, rx);
    check(rx, 8'h01);
    xfer(8'h00, rx);
    check(rx, FILLER_BYTE);
    // Lengths outside one to five are refused.
    offer(1'b0, 1'b1, 3'h0, 40'h5500000000, 12'h000, 12'h000, 1'b0, 8'h00);
    offer(1'b0, 1'b1, 3'h6, 40'h5500000000, 12'h000, 12'h000, 1'b0, 8'h00);
    print_verdict();
  end
endmodule : tsp_tb_top
